// file: scsm_pkg.sv
// Shared constants and types for the converter digital side and its serial host.
// Behaviour
// - Twelve decisions per conversion, MSB first to LSB.
// - Set trial bit, clear it if too high.
// - Correct earlier decisions only at tenth decision.
// - Tenth decision lands ten to eleven microseconds in.
// - Host keeps inputs static from 8 us until busy rises.
// - Host releases conversion start early in conversion.
// - Host avoids external shift clock edges during conversion.
// - Clock select low makes device serial master.
// - Busy falling starts shifting previous result out.
// - Serial clock idles low, data stable both edges.
// - Host is 12-bit slave selected by busy.
package scsm_pkg;
	localparam int RESULT_BITS = 12;
	localparam int CLK_NS = 100;
	localparam int TIMER_W = 8;
	localparam int COUNT_W = 5;
	localparam int PHASE_W = 3;

	// Conversion timing in nanoseconds and derived cycle counts.
	localparam int FIRST_DECISION_NS = 1500;
	localparam int STEP_NS = 1000;
	localparam int FIRST_DECISION_CYCLES = (FIRST_DECISION_NS + CLK_NS - 1) / CLK_NS;
	localparam int STEP_CYCLES = (STEP_NS + CLK_NS - 1) / CLK_NS;

	// Decision index of the tenth decision and the correction weight applied there.
	localparam logic [3:0] TENTH_BIT_INDEX = 4'h2;
	localparam int CORRECTION_WEIGHT = 8;

	// Internal serial clock: one bit per period, high in phases two to five.
	localparam int SCLK_PERIOD_NS = 800;
	localparam int SCLK_PERIOD_CYCLES = SCLK_PERIOD_NS / CLK_NS;
	localparam logic [PHASE_W-1:0] SCLK_RISE_AT = 3'h1;
	localparam logic [PHASE_W-1:0] SCLK_FALL_AT = 3'h5;
	localparam logic [PHASE_W-1:0] PHASE_LAST = PHASE_W'(SCLK_PERIOD_CYCLES - 1);

	// Host start pulse width; it must end well before the quiet window opens.
	localparam int START_LOW_NS = 1000;
	localparam int START_LOW_CYCLES = START_LOW_NS / CLK_NS;
	localparam int QUIET_START_NS = 8000;

	// Values after reset.
	localparam logic [RESULT_BITS-1:0] RESULT_RESET = 12'h000;
	localparam logic [2:0] SYNC_HIGH_RESET = 3'h7;

	typedef enum logic [1:0] {DEV_IDLE, DEV_CONVERT, DEV_FINISH} scsm_dev_state_type;
	typedef enum logic [1:0] {HOST_IDLE, HOST_START, HOST_WAIT} scsm_host_state_type;
endpackage

// file: scsm_link_if.sv
// Pin bundle between the converter digital side and the serial host.
`timescale 1ns/1ps
interface scsm_link_if;
	logic conversionStartN;
	logic externalShiftClock;
	logic clockSourceSelect;
	logic busy;
	logic serialClock;
	logic serialClockOe;
	logic serialResultOut;

	modport device (
		input conversionStartN,
		input externalShiftClock,
		input clockSourceSelect,
		output busy,
		output serialClock,
		output serialClockOe,
		output serialResultOut
	);

	modport host (
		output conversionStartN,
		output externalShiftClock,
		output clockSourceSelect,
		input busy,
		input serialClock,
		input serialClockOe,
		input serialResultOut
	);
endinterface

// file: scsm_device_end.sv
// Converter digital side: successive approximation sequencer and serial master.
`timescale 1ns/1ps
module scsm_device_end #(
	parameter int RESULT_BITS = scsm_pkg::RESULT_BITS
) (
	// Clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// Link pins
	scsm_link_if.device link,
	// User side: held input code, comparator noise, results
	input wire logic [RESULT_BITS-1:0] sampleCode,
	input wire logic compareFlip,
	output logic [RESULT_BITS-1:0] resultWord,
	output logic resultValid,
	output logic masterMode
);
	// Correction step at the tenth decision and the index of the first decision.
	localparam logic [RESULT_BITS:0] CORR = (RESULT_BITS + 1)'(scsm_pkg::CORRECTION_WEIGHT);
	localparam logic [3:0] TOP_INDEX = 4'(RESULT_BITS - 1);

	// Synchronised pins and their filtered levels.
	logic [2:0] startSync_r;
	logic [2:0] selSync_r;
	logic startLevel_r;
	logic masterMode_r;
	logic startFall;
	// Conversion sequencer state and the approximation being built.
	scsm_pkg::scsm_dev_state_type state_r;
	logic [scsm_pkg::TIMER_W-1:0] timer_r;
	logic [3:0] bitIdx_r;
	logic [RESULT_BITS-1:0] approx_r;
	logic [RESULT_BITS-1:0] approxNxt;
	// Completed result and the busy pin.
	logic [RESULT_BITS-1:0] result_r;
	logic resultValid_r;
	logic busy_r;
	// Serial master: shifter, bit counter, phase within a bit period and pins.
	logic [RESULT_BITS-1:0] shiftReg_r;
	logic [3:0] bitCnt_r;
	logic [scsm_pkg::PHASE_W-1:0] phase_r;
	logic shiftActive_r;
	logic sclk_r;
	logic serial_result_out_r;
	logic sclkOe_r;

	// One decision: optional correction at the tenth step, then trial and compare.
	function automatic logic [RESULT_BITS-1:0] sarStep(
		input logic [RESULT_BITS-1:0] base,
		input logic [RESULT_BITS-1:0] sample,
		input logic [3:0] idx,
		input logic flip
	);
		logic [RESULT_BITS:0] wide;
		logic [RESULT_BITS-1:0] mask;
		logic [RESULT_BITS-1:0] trial;
		logic tooHigh;
		wide = {1'b0, base};
		if (idx == scsm_pkg::TENTH_BIT_INDEX) begin
			// Earlier decisions may be off by one unit of the bit above; undo that here.
			if ({1'b0, sample} >= wide + CORR) begin
				wide = wide + CORR;
			end else if (sample < base) begin
				wide = wide - CORR;
			end
		end
		mask = {{(RESULT_BITS - 1){1'b0}}, 1'b1} << idx;
		trial = wide[RESULT_BITS-1:0] | mask;
		tooHigh = (trial > sample) ^ flip;
		sarStep = tooHigh ? wide[RESULT_BITS-1:0] : trial;
	endfunction

	// A synchronised level counts only once the last two stages agree, so a glitch is ignored.
	function automatic logic stagesAgree(input logic [2:0] stages);
		stagesAgree = (stages[1] == stages[2]);
	endfunction

	// The start and clock-select pins pass three flip-flops; a level counts once the last two agree.
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			startSync_r <= scsm_pkg::SYNC_HIGH_RESET;
			selSync_r <= scsm_pkg::SYNC_HIGH_RESET;
			startLevel_r <= 1'b1;
			masterMode_r <= 1'b0;
		end else begin
			startSync_r <= {startSync_r[1:0], link.conversionStartN};
			selSync_r <= {selSync_r[1:0], link.clockSourceSelect};
			if (stagesAgree(startSync_r)) begin
				startLevel_r <= startSync_r[2];
			end
			if (stagesAgree(selSync_r)) begin
				masterMode_r <= ~selSync_r[2];
			end
		end
	end

	assign startFall = startLevel_r && stagesAgree(startSync_r) && !startSync_r[2];
	assign approxNxt = sarStep(approx_r, sampleCode, bitIdx_r, compareFlip);

	// Conversion sequencer: first decision after a settling delay, then one per step.
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			state_r <= scsm_pkg::DEV_IDLE;
			timer_r <= '0;
			bitIdx_r <= '0;
			approx_r <= '0;
			busy_r <= 1'b1;
			result_r <= scsm_pkg::RESULT_RESET;
			resultValid_r <= 1'b0;
		end else begin
			resultValid_r <= 1'b0;
			case (state_r)
				scsm_pkg::DEV_IDLE: begin
					if (startFall) begin
						state_r <= scsm_pkg::DEV_CONVERT;
						busy_r <= 1'b0;
						timer_r <= scsm_pkg::TIMER_W'(scsm_pkg::FIRST_DECISION_CYCLES - 1);
						bitIdx_r <= TOP_INDEX;
						approx_r <= '0;
					end
				end
				scsm_pkg::DEV_CONVERT: begin
					// Count down to the next decision, then decide the bit under test.
					if (timer_r != '0) begin
						timer_r <= timer_r - 1'b1;
					end else begin
						approx_r <= approxNxt;
						if (bitIdx_r == 4'h0) begin
							state_r <= scsm_pkg::DEV_FINISH;
						end else begin
							bitIdx_r <= bitIdx_r - 1'b1;
							timer_r <= scsm_pkg::TIMER_W'(scsm_pkg::STEP_CYCLES - 1);
						end
					end
				end
				scsm_pkg::DEV_FINISH: begin
					// Busy only rises once the previous result has left the shifter.
					if (!shiftActive_r) begin
						state_r <= scsm_pkg::DEV_IDLE;
						busy_r <= 1'b1;
						result_r <= approx_r;
						resultValid_r <= 1'b1;
					end
				end
				default: begin
					state_r <= scsm_pkg::DEV_IDLE;
				end
			endcase
		end
	end

	// Serial master: on the busy fall the previous result leaves MSB first.
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			shiftReg_r <= '0;
			bitCnt_r <= '0;
			phase_r <= '0;
			shiftActive_r <= 1'b0;
			sclk_r <= 1'b0;
			serial_result_out_r <= 1'b0;
		end else if (state_r == scsm_pkg::DEV_IDLE && startFall && masterMode_r) begin
			shiftActive_r <= 1'b1;
			serial_result_out_r <= result_r[RESULT_BITS-1];
			shiftReg_r <= result_r << 1;
			bitCnt_r <= TOP_INDEX;
			phase_r <= '0;
			sclk_r <= 1'b0;
		end else if (shiftActive_r) begin
			// Data changes only at period start, edges sit mid-period for margin.
			if (phase_r == scsm_pkg::SCLK_RISE_AT) begin
				sclk_r <= 1'b1;
			end
			if (phase_r == scsm_pkg::SCLK_FALL_AT) begin
				sclk_r <= 1'b0;
			end
			if (phase_r == scsm_pkg::PHASE_LAST) begin
				phase_r <= '0;
				// The last bit has had its full period; the data line returns low.
				if (bitCnt_r == 4'h0) begin
					shiftActive_r <= 1'b0;
					serial_result_out_r <= 1'b0;
				end else begin
					serial_result_out_r <= shiftReg_r[RESULT_BITS-1];
					shiftReg_r <= shiftReg_r << 1;
					bitCnt_r <= bitCnt_r - 1'b1;
				end
			end else begin
				phase_r <= phase_r + 1'b1;
			end
		end
	end

	// Serial clock is driven only in master mode.
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			sclkOe_r <= 1'b0;
		end else begin
			sclkOe_r <= masterMode_r;
		end
	end

	// Pins and user outputs come straight from their flip-flops.
	assign link.busy = busy_r;
	assign link.serialClock = sclk_r;
	assign link.serialClockOe = sclkOe_r;
	assign link.serialResultOut = serial_result_out_r;
	assign resultWord = result_r;
	assign resultValid = resultValid_r;
	assign masterMode = masterMode_r;
endmodule

// file: scsm_host_end.sv
// Serial host end: starts conversions and receives results as a busy-selected slave.
`timescale 1ns/1ps
module scsm_host_end #(
	parameter int RESULT_BITS = scsm_pkg::RESULT_BITS
) (
	// Clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// Link pins
	scsm_link_if.host link,
	// User side
	input wire logic startRequest,
	output logic [RESULT_BITS-1:0] resultWord,
	output logic resultValid,
	output logic frameError,
	output logic convBusy
);
	localparam logic [scsm_pkg::COUNT_W-1:0] FULL_COUNT = scsm_pkg::COUNT_W'(RESULT_BITS);

	logic [2:0] busySync_r;
	logic [2:0] sclkSync_r;
	logic [2:0] dataSync_r;
	logic busyLevel_r;
	logic sclkLevel_r;
	logic dataLevel_r;
	logic busyFall;
	logic busyRise;
	logic sclkRise;
	scsm_pkg::scsm_host_state_type state_r;
	logic [scsm_pkg::TIMER_W-1:0] timer_r;
	logic startN_r;
	logic extClk_r;
	logic srcSel_r;
	logic inFrame_r;
	logic [RESULT_BITS-1:0] rxShift_r;
	logic [scsm_pkg::COUNT_W-1:0] rxCount_r;
	logic [RESULT_BITS-1:0] result_r;
	logic resultValid_r;
	logic frameError_r;

	// A synchronised level counts only once the last two stages agree, so a glitch is ignored.
	function automatic logic stagesAgree(input logic [2:0] stages);
		stagesAgree = (stages[1] == stages[2]);
	endfunction

	// Link inputs pass three flip-flops; a level counts once the last two agree.
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			busySync_r <= scsm_pkg::SYNC_HIGH_RESET;
			sclkSync_r <= '0;
			dataSync_r <= '0;
			busyLevel_r <= 1'b1;
			sclkLevel_r <= 1'b0;
			dataLevel_r <= 1'b0;
		end else begin
			busySync_r <= {busySync_r[1:0], link.busy};
			sclkSync_r <= {sclkSync_r[1:0], link.serialClock & link.serialClockOe};
			dataSync_r <= {dataSync_r[1:0], link.serialResultOut};
			if (stagesAgree(busySync_r)) begin
				busyLevel_r <= busySync_r[2];
			end
			if (stagesAgree(sclkSync_r)) begin
				sclkLevel_r <= sclkSync_r[2];
			end
			if (stagesAgree(dataSync_r)) begin
				dataLevel_r <= dataSync_r[2];
			end
		end
	end

	assign busyFall = busyLevel_r && stagesAgree(busySync_r) && !busySync_r[2];
	assign busyRise = !busyLevel_r && stagesAgree(busySync_r) && busySync_r[2];
	assign sclkRise = !sclkLevel_r && stagesAgree(sclkSync_r) && sclkSync_r[2];

	// Start control: one short low pulse, then every input stays still.
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			state_r <= scsm_pkg::HOST_IDLE;
			timer_r <= '0;
			startN_r <= 1'b1;
		end else begin
			case (state_r)
				scsm_pkg::HOST_IDLE: begin
					if (startRequest && busyLevel_r) begin
						state_r <= scsm_pkg::HOST_START;
						startN_r <= 1'b0;
						timer_r <= scsm_pkg::TIMER_W'(scsm_pkg::START_LOW_CYCLES - 1);
					end
				end
				scsm_pkg::HOST_START: begin
					if (timer_r != '0) begin
						timer_r <= timer_r - 1'b1;
					end else begin
						startN_r <= 1'b1;
						state_r <= scsm_pkg::HOST_WAIT;
					end
				end
				scsm_pkg::HOST_WAIT: begin
					// No new start until busy rises, keeping the late window quiet.
					if (busyRise) begin
						state_r <= scsm_pkg::HOST_IDLE;
					end
				end
				default: begin
					state_r <= scsm_pkg::HOST_IDLE;
				end
			endcase
		end
	end

	// Internal clock mode selected and the external shift clock held still.
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			extClk_r <= 1'b0;
			srcSel_r <= 1'b0;
		end else begin
			extClk_r <= 1'b0;
			srcSel_r <= 1'b0;
		end
	end

	// Slave receiver: busy low selects, bits taken on serial clock rise.
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			inFrame_r <= 1'b0;
			rxShift_r <= '0;
			rxCount_r <= '0;
			result_r <= scsm_pkg::RESULT_RESET;
			resultValid_r <= 1'b0;
			frameError_r <= 1'b0;
		end else begin
			resultValid_r <= 1'b0;
			frameError_r <= 1'b0;
			if (busyFall) begin
				inFrame_r <= 1'b1;
				rxCount_r <= '0;
				rxShift_r <= '0;
			end else if (busyRise && inFrame_r) begin
				inFrame_r <= 1'b0;
				if (rxCount_r == FULL_COUNT) begin
					result_r <= rxShift_r;
					resultValid_r <= 1'b1;
				end else begin
					frameError_r <= 1'b1;
				end
			end else if (inFrame_r && sclkRise && rxCount_r != {scsm_pkg::COUNT_W{1'b1}}) begin
				rxShift_r <= {rxShift_r[RESULT_BITS-2:0], dataLevel_r};
				rxCount_r <= rxCount_r + 1'b1;
			end
		end
	end

	assign link.conversionStartN = startN_r;
	assign link.externalShiftClock = extClk_r;
	assign link.clockSourceSelect = srcSel_r;
	assign resultWord = result_r;
	assign resultValid = resultValid_r;
	assign frameError = frameError_r;
	assign convBusy = busyLevel_r;
endmodule

// file: scsm_link_asserts.sv
// Concurrent checks on the link between the converter side and the serial host.
`timescale 1ns/1ps
module scsm_link_asserts (
	// Clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// Link pins
	input wire logic conversionStartN,
	input wire logic externalShiftClock,
	input wire logic clockSourceSelect,
	input wire logic busy,
	input wire logic serialClock,
	input wire logic serialClockOe,
	input wire logic serialResultOut
);
	logic [7:0] lowCount_r;
	logic [4:0] riseCount_r;
	logic sclkPrev_r;

	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);

	// Counts cycles of the current conversion; it saturates so it cannot wrap into the window.
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			lowCount_r <= 8'h00;
		end else if (busy) begin
			lowCount_r <= 8'h00;
		end else if (lowCount_r != 8'hff) begin
			lowCount_r <= lowCount_r + 8'h01;
		end
	end

	// Counts serial clock rises within one busy-low frame.
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			sclkPrev_r <= 1'b0;
			riseCount_r <= 5'h00;
		end else begin
			sclkPrev_r <= serialClock;
			if (busy) begin
				riseCount_r <= 5'h00;
			end else if (serialClock && !sclkPrev_r && riseCount_r != 5'h1f) begin
				riseCount_r <= riseCount_r + 5'h01;
			end
		end
	end

	property p_busySpan;
		$rose(busy) |-> lowCount_r inside {[8'd118:8'd132]};
	endproperty
	a_busySpan: assert property (p_busySpan) else $error("busy low span out of range");

	property p_frameBits;
		$rose(busy) |-> riseCount_r == 5'd12;
	endproperty
	a_frameBits: assert property (p_frameBits) else $error("frame did not carry 12 bits");

	property p_shiftStart;
		$fell(busy) |-> !serialClock ##2 serialClock;
	endproperty
	a_shiftStart: assert property (p_shiftStart) else $error("shift did not start");

	property p_masterOe;
		!busy && !clockSourceSelect |-> serialClockOe;
	endproperty
	a_masterOe: assert property (p_masterOe) else $error("device not driving clock");

	property p_clockIdle;
		busy |-> !serialClock;
	endproperty
	a_clockIdle: assert property (p_clockIdle) else $error("serial clock active while idle");

	property p_clockHigh;
		$rose(serialClock) |-> serialClock[*4] ##1 !serialClock;
	endproperty
	a_clockHigh: assert property (p_clockHigh) else $error("serial clock high width wrong");

	property p_dataStable;
		serialClock && $past(serialClock) |-> $stable(serialResultOut);
	endproperty
	a_dataStable: assert property (p_dataStable) else $error("data moved while clock high");

	property p_startPulse;
		$fell(conversionStartN) |-> ##9 !conversionStartN ##1 conversionStartN;
	endproperty
	a_startPulse: assert property (p_startPulse) else $error("start pulse width wrong");

	property p_quietInputs;
		lowCount_r >= 8'd76 |-> $stable(conversionStartN) && $stable(clockSourceSelect);
	endproperty
	a_quietInputs: assert property (p_quietInputs) else $error("input moved in quiet window");

	property p_shiftClockQuiet;
		!busy |-> $stable(externalShiftClock);
	endproperty
	a_shiftClockQuiet: assert property (p_shiftClockQuiet) else $error("shift clock moved");
endmodule

// file: sar_conversion_serial_master_tb.sv
// Self-checking bench joining the converter side and the serial host.
`timescale 1ns/1ps
module sar_conversion_serial_master_tb;
	typedef struct packed {logic [11:0] code; logic [11:0] expected;} scsm_row_type;
	localparam scsm_row_type ROWS [7] = '{'{12'h000, 12'h000}, '{12'hfff, 12'hfff},
		'{12'h800, 12'h800}, '{12'h7ff, 12'h7ff}, '{12'ha5a, 12'ha5a},
		'{12'h001, 12'h001}, '{12'h555, 12'h555}};
	logic clk;
	logic sys_rst;
	logic [11:0] sampleCode;
	logic compareFlip;
	logic startRequest;
	logic [11:0] devWord;
	logic devValid;
	logic masterMode;
	logic [11:0] hostWord;
	logic hostValid;
	logic frameError;
	logic hostBusy;
	logic sawFrameError = 1'b0;
	logic [11:0] prev;
	int fails;
	int compares;

	scsm_link_if link();
	scsm_device_end scsm_device_end_inst (.clk(clk), .sys_rst(sys_rst), .link(link),
		.sampleCode(sampleCode), .compareFlip(compareFlip), .resultWord(devWord),
		.resultValid(devValid), .masterMode(masterMode));
	scsm_host_end scsm_host_end_inst (.clk(clk), .sys_rst(sys_rst), .link(link),
		.startRequest(startRequest), .resultWord(hostWord), .resultValid(hostValid),
		.frameError(frameError), .convBusy(hostBusy));
	scsm_link_asserts scsm_link_asserts_inst (.clk(clk), .sys_rst(sys_rst),
		.conversionStartN(link.conversionStartN), .externalShiftClock(link.externalShiftClock),
		.clockSourceSelect(link.clockSourceSelect), .busy(link.busy),
		.serialClock(link.serialClock), .serialClockOe(link.serialClockOe),
		.serialResultOut(link.serialResultOut));

	// Makes the 10 MHz clock.
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end

	// Remembers any frame error seen on the host side.
	always @(posedge clk) begin
		if (frameError === 1'b1) sawFrameError <= 1'b1;
	end

	// Moves to a point shortly after the next rising edge.
	task automatic tick();
		@(posedge clk);
		#10;
	endtask

	// Compares one value and counts the outcome.
	task automatic check(input logic [11:0] got, input logic [11:0] exp, input string what);
		compares++;
		if (got !== exp) begin
			fails++;
			$display("wrong value at %0t: %s got %h", $time, what, got);
		end
	endtask

	// Waits for a flag under a bound; which selects busy low, device result or host result.
	task automatic wait_for(input int which, input int limit);
		int n;
		n = 0;
		while (n < limit && !((which == 0 && link.busy === 1'b0) ||
			(which == 1 && devValid === 1'b1) || (which == 2 && hostValid === 1'b1))) begin
			tick();
			n++;
		end
		if (n >= limit) begin
			fails++;
			$display("wrong value at %0t: wait %0d timed out", $time, which);
		end
	endtask

	// Requests a conversion and returns in the cycle where busy has fallen.
	task automatic start_conversion_start_n(input logic [11:0] code);
		sampleCode = code;
		startRequest = 1'b1;
		tick();
		startRequest = 1'b0;
		wait_for(0, 20);
	endtask

	// Runs a whole conversion, optionally disturbing the comparator for five cycles.
	task automatic run_conversion_start_n(input logic [11:0] code, input int flipAt);
		start_conversion_start_n(code);
		if (flipAt >= 0) begin
			repeat (flipAt) tick();
			compareFlip = 1'b1;
			repeat (5) tick();
			compareFlip = 1'b0;
		end
		wait_for(1, 400);
	endtask

	// Checks the word the host took during the last conversion.
	task automatic host_got(input logic [11:0] exp);
		wait_for(2, 20);
		check(hostWord, exp, "host word");
	endtask

	// Prints the counts and the verdict, then ends the run.
	task automatic report_and_stop();
		$display("compares %0d fails %0d", compares, fails);
		if (fails == 0 && compares > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	// Cuts a hung run short.
	initial begin
		#3000000;
		fails++;
		report_and_stop();
	end

	// Main sequence: table of plain conversions, then the awkward cases.
	initial begin
		fails = 0;
		compares = 0;
		sys_rst = 1'b1;
		sampleCode = 12'h000;
		compareFlip = 1'b0;
		startRequest = 1'b0;
		prev = 12'h000;
		repeat (20) tick();
		sys_rst = 1'b0;
		repeat (6) tick();
		check({11'h000, masterMode}, 12'h001, "master mode");
		check({11'h000, link.busy}, 12'h001, "idle busy");
		check({11'h000, hostBusy}, 12'h001, "host idle busy");
		for (int i = 0; i < 7; i++) begin
			run_conversion_start_n(ROWS[i].code, -1);
			check(devWord, ROWS[i].expected, "device word");
			host_got(prev);
			prev = ROWS[i].expected;
		end
		// A slip on bit 3 is repaired at the tenth decision; one on bit 0 is not.
		run_conversion_start_n(12'h5a8, 91);
		check(devWord, 12'h5a8, "corrected word");
		host_got(prev);
		run_conversion_start_n(12'h5a8, 121);
		check(devWord, 12'h5a9, "late slip word");
		host_got(12'h5a8);
		// A second request in mid-conversion must not start anything.
		start_conversion_start_n(12'h0f0);
		repeat (30) tick();
		check({11'h000, hostBusy}, 12'h000, "host sees busy low");
		startRequest = 1'b1;
		tick();
		startRequest = 1'b0;
		wait_for(1, 400);
		check(devWord, 12'h0f0, "word after refused start");
		host_got(12'h5a9);
		repeat (40) tick();
		check({11'h000, link.busy}, 12'h001, "no extra conversion");
		check({11'h000, hostBusy}, 12'h001, "host sees busy high");
		// Reset in mid-conversion, then the first frame carries the reset result.
		start_conversion_start_n(12'h333);
		repeat (50) tick();
		sys_rst = 1'b1;
		tick();
		check({11'h000, link.busy}, 12'h001, "busy in reset");
		check({11'h000, link.serialClock}, 12'h000, "clock in reset");
		check(devWord, 12'h000, "word in reset");
		repeat (3) tick();
		sys_rst = 1'b0;
		repeat (6) tick();
		run_conversion_start_n(12'h444, -1);
		check(devWord, 12'h444, "word after reset");
		host_got(12'h000);
		check({11'h000, sawFrameError}, 12'h000, "frame error seen");
		report_and_stop();
	end
endmodule
